// ===== design/fre_pkg.sv
// Purpose: constants, types and helpers of the row erase call block
// Assumes: 32-bit AXI4-Lite register slave, 125 MHz aclk
package fre_pkg;
	// --------------------------------------------------------------
	// register map (byte offsets)
	// --------------------------------------------------------------
	localparam logic [7:0] REG_CHAN = 8'h00;
	localparam logic [7:0] REG_CTRL = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] REG_IEN  = 8'h0c;
	localparam logic [7:0] REG_ICLR = 8'h10;
	localparam logic [7:0] REG_VSEL = 8'h14;
	localparam int CTRL_START = 0;
	localparam int CTRL_REQ_LO = 1;
	localparam int CTRL_BUSY = 8;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ERR = 1;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// --------------------------------------------------------------
	// call encoding
	// --------------------------------------------------------------
	localparam logic [1:0] REQ_DEBUG = 2'h0;
	localparam logic [7:0] OP_ROW_ERASE = 8'h1c;
	localparam logic [7:0] OP_SOFT_RESET = 8'h1b;
	localparam logic [7:0] BLOCK_ON = 8'h01;
	localparam logic [6:0] RTYPE_SYS = 7'h00;
	localparam logic [6:0] RTYPE_APP = 7'h01;
	localparam int BIT_STALL = 2;
	localparam int BIT_HWSEQ = 1;
	localparam int BIT_ARGS_IN_DATA = 0;
	localparam logic [3:0] STAT_OK = 4'ha;
	localparam logic [3:0] STAT_ERR = 4'hf;
	localparam logic [27:0] ERR_NONE = 28'h0000000;
	localparam logic [27:0] ERR_BAD_OP = 28'h0000001;
	localparam logic [27:0] ERR_ALIGN = 28'h0000002;
	localparam logic [27:0] ERR_FLASH = 28'h0000003;
	localparam logic [31:0] PARAM_ADDR_OFS = 32'h00000004;
	localparam logic [31:0] ROW_BYTES = 32'h00000200;
	// --------------------------------------------------------------
	// high voltage pulse timing
	// --------------------------------------------------------------
	localparam int CLK_NS = 8;
	localparam int HV_PULSE_NS = 1000;
	localparam int HV_GAP_NS = 1000;
	localparam logic [7:0] HV_PULSE_CYC =
		8'((HV_PULSE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] HV_GAP_CYC =
		8'((HV_GAP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] HV_PULSES = 4'h4;
	// --------------------------------------------------------------
	// types
	// --------------------------------------------------------------
	typedef struct packed {
		logic        req;
		logic        we;
		logic [31:0] addr;
		logic [31:0] wdata;
	} fre_sram_req_t;
	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
	} fre_sram_rsp_t;
	typedef struct packed {
		logic        hv_pulse;
		logic        erase_act;
		logic [31:0] row_addr;
	} fre_flash_t;
	typedef enum logic [6:0] {
		ST_IDLE    = 7'b0000001,
		ST_RD_OP   = 7'b0000010,
		ST_RD_ADDR = 7'b0000100,
		ST_ERASE   = 7'b0001000,
		ST_WR_RET  = 7'b0010000,
		ST_DONE    = 7'b0100000,
		ST_RESET   = 7'b1000000
	} fre_state_t;
	typedef enum logic [3:0] {
		ES_IDLE  = 4'b0001,
		ES_PULSE = 4'b0010,
		ES_GAP   = 4'b0100,
		ES_FW    = 4'b1000
	} fre_eseq_t;
	// base address of the row holding any byte
	function automatic logic [31:0] fre_row_base(input logic [31:0] a);
		return a & ~(ROW_BYTES - 32'h00000001);
	endfunction : fre_row_base
	// byte-lane merge of a register write
	function automatic logic [31:0] fre_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : fre_merge
endpackage : fre_pkg

// ===== design/fre_erase_seq.sv
// Purpose: erase sequencer for one flash row
// Assumes: flash array reports failure level at finish
// Notes: firmware mode passes firmware pulse request through
`timescale 1ns/1ps
`default_nettype none
module fre_erase_seq
	import fre_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// request
	input  wire logic        start,
	input  wire logic [31:0] row_addr,
	input  wire logic        hw_seq,
	// firmware control and flash status
	input  wire logic        fw_hv_pulse,
	input  wire logic        fw_done,
	input  wire logic        flash_fail,
	// results
	output fre_flash_t       flash,
	output logic             done,
	output logic             fail
);
	typedef struct packed {
		fre_eseq_t  st;
		logic [7:0] cnt;
		logic [3:0] pulses;
		fre_flash_t fl;
		logic       done;
		logic       fail;
	} fre_seq_st_t;

	fre_seq_st_t s;
	fre_seq_st_t n;

	// --------------------------------------------------------------
	// sequencing
	// --------------------------------------------------------------
	always_comb begin
		n = s;
		n.done = 1'b0;
		n.fail = 1'b0;
		case (s.st)
			ES_IDLE: begin
				if (start) begin
					n.fl.row_addr = fre_row_base(row_addr);
					n.fl.erase_act = 1'b1;
					n.cnt = 8'h00;
					n.pulses = 4'h0;
					if (hw_seq) begin
						n.fl.hv_pulse = 1'b1;
						n.st = ES_PULSE;
					end else begin
						n.st = ES_FW;
					end
				end
			end
			ES_PULSE: begin
				n.cnt = s.cnt + 8'h01;
				if (s.cnt == HV_PULSE_CYC - 8'h01) begin
					n.fl.hv_pulse = 1'b0;
					n.cnt = 8'h00;
					n.pulses = s.pulses + 4'h1;
					n.st = ES_GAP;
				end
			end
			ES_GAP: begin
				n.cnt = s.cnt + 8'h01;
				if (s.cnt == HV_GAP_CYC - 8'h01) begin
					n.cnt = 8'h00;
					if (s.pulses == HV_PULSES) begin
						n.st = ES_IDLE;
						n.fl.erase_act = 1'b0;
						n.done = 1'b1;
						n.fail = flash_fail;
					end else begin
						n.fl.hv_pulse = 1'b1;
						n.st = ES_PULSE;
					end
				end
			end
			ES_FW: begin
				n.fl.hv_pulse = fw_hv_pulse;
				if (fw_done) begin
					n.fl.hv_pulse = 1'b0;
					n.fl.erase_act = 1'b0;
					n.st = ES_IDLE;
					n.done = 1'b1;
					n.fail = flash_fail;
				end
			end
			default: begin
				n.st = ES_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '{st: ES_IDLE, default: '0};
		end else begin
			s <= n;
		end
	end

	assign flash = s.fl;
	assign done = s.done;
	assign fail = s.fail;

	hw_seq_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(s.st == ES_IDLE && start) |=> (s.fl.hv_pulse == $past(hw_seq))
		&& (s.st == ($past(hw_seq) ? ES_PULSE : ES_FW)))
		else $error("sequencing mode does not follow bit 1");
	row_base_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(s.st == ES_IDLE && start) |=>
		s.fl.row_addr == fre_row_base($past(row_addr)))
		else $error("erase row address is not the row base");
endmodule : fre_erase_seq
`default_nettype wire

// ===== design/fre_row_erase.sv
// Purpose: row erase and soft reset call interpreter, AXI4-Lite slave
// Assumes: parameter block reached over a req/ack SRAM port
// Notes: busy calls ignore new start writes
`timescale 1ns/1ps
`default_nettype none
module fre_row_erase
	import fre_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// axi4-lite read
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// sram port for the parameter block
	output fre_sram_req_t    sram_o,
	input  wire fre_sram_rsp_t sram_i,
	// flash array
	output fre_flash_t       flash_o,
	input  wire logic        flash_fail,
	input  wire logic        fw_hv_pulse,
	input  wire logic        fw_done,
	// system side
	output logic             hold_helper_core,
	output logic             stall_flash_reads,
	output logic             sys_reset_req,
	output logic             app_reset_req,
	output logic             vcc_sel,
	output logic             call_done,
	output logic             irq
);
	typedef struct packed {
		fre_state_t    st;
		logic [31:0]   chan;
		logic [1:0]    req;
		logic [31:0]   ptr;
		logic [31:0]   opw;
		logic [31:0]   ret;
		logic          ret_to_sram;
		logic          rst_pend;
		logic [1:0]    stat;
		logic [1:0]    ien;
		logic          irq;
		logic          vsel;
		fre_sram_req_t sram;
		logic          erase_go;
		logic          blk_helper;
		logic          stall_rd;
		logic          hwseq;
		logic          done_pulse;
		logic          sys_rst;
		logic          app_rst;
		logic          aw_have;
		logic          w_have;
		logic [7:0]    awaddr;
		logic [31:0]   wdata;
		logic [3:0]    wstrb;
		logic          awready;
		logic          wready;
		logic          bvalid;
		logic [1:0]    bresp;
		logic          arready;
		logic          rvalid;
		logic [31:0]   rdata;
		logic [1:0]    rresp;
	} fre_top_st_t;

	fre_top_st_t s;
	fre_top_st_t n;
	logic        seq_done;
	logic        seq_fail;

	// --------------------------------------------------------------
	// erase sequencer
	// --------------------------------------------------------------
	fre_erase_seq u_seq (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.start       (s.erase_go),
		.row_addr    (s.ptr),
		.hw_seq      (s.hwseq),
		.fw_hv_pulse (fw_hv_pulse),
		.fw_done     (fw_done),
		.flash_fail  (flash_fail),
		.flash       (flash_o),
		.done        (seq_done),
		.fail        (seq_fail)
	);

	// --------------------------------------------------------------
	// bus slave and call sequencing
	// --------------------------------------------------------------
	always_comb begin
		logic       do_start;
		logic [1:0] clr;
		logic [1:0] set;
		do_start = 1'b0;
		clr = 2'h0;
		set = 2'h0;
		n = s;
		n.erase_go = 1'b0;
		n.done_pulse = 1'b0;
		n.sys_rst = 1'b0;
		n.app_rst = 1'b0;
		// write address and data are taken in either order
		if (awvalid && s.awready) begin
			n.aw_have = 1'b1;
			n.awaddr = awaddr;
		end
		if (wvalid && s.wready) begin
			n.w_have = 1'b1;
			n.wdata = wdata;
			n.wstrb = wstrb;
		end
		if (s.bvalid && bready) begin
			n.bvalid = 1'b0;
		end
		if (n.aw_have && n.w_have && !s.bvalid) begin
			n.aw_have = 1'b0;
			n.w_have = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = RESP_OK;
			case (n.awaddr)
				REG_CHAN: n.chan = fre_merge(s.chan, n.wdata, n.wstrb);
				REG_CTRL: begin
					if (n.wstrb[0] && n.wdata[CTRL_START]
						&& s.st == ST_IDLE) begin
						do_start = 1'b1;
						n.req = n.wdata[CTRL_REQ_LO +: 2];
					end
				end
				REG_STAT: n.bresp = RESP_OK;
				REG_IEN: n.ien = n.wstrb[0] ? n.wdata[1:0] : s.ien;
				REG_ICLR: clr = n.wstrb[0] ? n.wdata[1:0] : 2'h0;
				REG_VSEL: n.vsel = n.wstrb[0] ? n.wdata[0] : s.vsel;
				default: n.bresp = RESP_SLVERR;
			endcase
		end
		// read channel, one outstanding read
		if (s.rvalid && rready) begin
			n.rvalid = 1'b0;
		end
		if (arvalid && s.arready) begin
			n.rvalid = 1'b1;
			n.rresp = RESP_OK;
			case (araddr)
				REG_CHAN: n.rdata = s.chan;
				REG_CTRL: n.rdata = {23'h0, s.st != ST_IDLE, 5'h0,
					s.req, 1'b0};
				REG_STAT: n.rdata = {30'h0, s.stat};
				REG_IEN:  n.rdata = {30'h0, s.ien};
				REG_ICLR: n.rdata = 32'h00000000;
				REG_VSEL: n.rdata = {31'h0, s.vsel};
				default: begin
					n.rdata = 32'h00000000;
					n.rresp = RESP_SLVERR;
				end
			endcase
		end
		// call state machine; its channel word write beats the bus
		case (s.st)
			ST_IDLE: begin
				if (do_start) begin
					n.ptr = s.chan;
					n.rst_pend = 1'b0;
					if (n.req == REQ_DEBUG
						&& s.chan[31:24] == OP_SOFT_RESET
						&& s.chan[BIT_ARGS_IN_DATA]) begin
						n.opw = s.chan;
						n.ret_to_sram = 1'b0;
						n.st = ST_DONE;
						if (s.chan[7:1] == RTYPE_SYS
							|| s.chan[7:1] == RTYPE_APP) begin
							n.ret = {STAT_OK, ERR_NONE};
							n.rst_pend = 1'b1;
						end else begin
							n.ret = {STAT_ERR, ERR_BAD_OP};
						end
					end else if (s.chan[1:0] != 2'h0) begin
						// misaligned pointer: nowhere safe in sram
						n.ret = {STAT_ERR, ERR_ALIGN};
						n.ret_to_sram = 1'b0;
						n.st = ST_DONE;
					end else begin
						n.sram = '{req: 1'b1, we: 1'b0,
							addr: s.chan, wdata: 32'h0};
						n.st = ST_RD_OP;
					end
				end
			end
			ST_RD_OP: begin
				if (sram_i.ack) begin
					n.opw = sram_i.rdata;
					n.sram.req = 1'b0;
					n.ret_to_sram = s.req != REQ_DEBUG;
					n.st = n.ret_to_sram ? ST_WR_RET : ST_DONE;
					if (sram_i.rdata[31:24] == OP_ROW_ERASE) begin
						n.ret_to_sram = 1'b1;
						n.sram.req = 1'b1;
						n.sram.addr = s.ptr + PARAM_ADDR_OFS;
						n.st = ST_RD_ADDR;
					end else if (sram_i.rdata[31:24] == OP_SOFT_RESET
						&& (sram_i.rdata[7:1] == RTYPE_SYS
						|| sram_i.rdata[7:1] == RTYPE_APP)) begin
						n.ret = {STAT_OK, ERR_NONE};
						n.rst_pend = 1'b1;
					end else begin
						n.ret = {STAT_ERR, ERR_BAD_OP};
					end
				end
			end
			ST_RD_ADDR: begin
				if (sram_i.ack) begin
					n.sram.req = 1'b0;
					n.ptr = sram_i.rdata;
					n.erase_go = 1'b1;
					n.blk_helper = s.opw[15:8] == BLOCK_ON;
					n.stall_rd = s.opw[BIT_STALL];
					n.hwseq = s.opw[BIT_HWSEQ];
					n.st = ST_ERASE;
				end
			end
			ST_ERASE: begin
				if (seq_done) begin
					n.blk_helper = 1'b0;
					n.stall_rd = 1'b0;
					n.ptr = s.chan;
					n.ret = seq_fail ? {STAT_ERR, ERR_FLASH}
						: {STAT_OK, ERR_NONE};
					n.st = ST_WR_RET;
				end
			end
			ST_WR_RET: begin
				if (!s.sram.req) begin
					n.sram = '{req: 1'b1, we: 1'b1,
						addr: s.ptr, wdata: s.ret};
				end else if (sram_i.ack) begin
					n.sram.req = 1'b0;
					n.sram.we = 1'b0;
					n.st = ST_DONE;
				end
			end
			ST_DONE: begin
				if (!s.ret_to_sram) begin
					n.chan = s.ret;
				end
				n.done_pulse = 1'b1;
				set[IRQ_DONE] = 1'b1;
				set[IRQ_ERR] = s.ret[31:28] == STAT_ERR;
				// reset goes out last so the return word is in place
				n.st = s.rst_pend ? ST_RESET : ST_IDLE;
			end
			ST_RESET: begin
				n.sys_rst = s.opw[7:1] == RTYPE_SYS;
				n.app_rst = s.opw[7:1] == RTYPE_APP;
				n.rst_pend = 1'b0;
				n.st = ST_IDLE;
			end
			default: begin
				n.st = ST_IDLE;
			end
		endcase
		// sticky status: a new event wins over a clear
		n.stat = (s.stat & ~clr) | set;
		n.irq = |(n.stat & n.ien);
		n.awready = !n.aw_have && !n.bvalid;
		n.wready = !n.w_have && !n.bvalid;
		n.arready = !n.rvalid;
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '{st: ST_IDLE, default: '0};
		end else begin
			s <= n;
		end
	end

	// --------------------------------------------------------------
	// outputs, all from flops
	// --------------------------------------------------------------
	assign awready = s.awready;
	assign wready = s.wready;
	assign bresp = s.bresp;
	assign bvalid = s.bvalid;
	assign arready = s.arready;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	assign rvalid = s.rvalid;
	assign sram_o = s.sram;
	assign hold_helper_core = s.blk_helper;
	assign stall_flash_reads = s.stall_rd;
	assign sys_reset_req = s.sys_rst;
	assign app_reset_req = s.app_rst;
	assign vcc_sel = s.vsel;
	assign call_done = s.done_pulse;
	assign irq = s.irq;

	chan_return_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(s.st == ST_DONE && !s.ret_to_sram) |=> s.chan == $past(s.ret))
		else $error("return word missing from channel word");
	sram_return_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(s.st == ST_WR_RET && s.sram.req) |-> s.sram.we
		&& s.sram.addr == s.ptr && s.sram.wdata == s.ret)
		else $error("return write to parameter block is wrong");
	ret_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s.st == ST_DONE |-> (s.ret[31:28] == STAT_OK
		&& s.ret[27:0] == ERR_NONE) || s.ret[31:28] == STAT_ERR)
		else $error("return status nibble is invalid");
	erase_op_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s.erase_go |-> s.opw[31:24] == OP_ROW_ERASE)
		else $error("erase started without row erase opcode");
	hold_core_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s.erase_go |-> s.blk_helper == (s.opw[15:8] == BLOCK_ON))
		else $error("helper core hold does not match blocking byte");
	stall_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s.erase_go |-> s.stall_rd == s.opw[BIT_STALL] ##1
		flash_o.erase_act)
		else $error("read stall does not match bit 2");
	reset_kind_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(s.sys_rst) || $rose(s.app_rst) |->
		$past(s.done_pulse) && (s.sys_rst != s.app_rst))
		else $error("soft reset kind or order is wrong");
	done_after_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s.done_pulse |-> !flash_o.erase_act && !s.blk_helper
		##1 !s.done_pulse)
		else $error("completion signalled during erase");
endmodule : fre_row_erase
`default_nettype wire

// ===== dv/fre_sram_model.sv
// Purpose: parameter block memory seen by the call block
// Assumes: req held until ack; ack is a one-cycle pulse
// Notes: lat sets the ack delay so that prompt and slow replies both occur
`timescale 1ns/1ps
`default_nettype none
module fre_sram_model
	import fre_pkg::*;
(
	// clock and reset
	input  wire logic          aclk,
	input  wire logic          aresetn,
	// reply delay in cycles
	input  wire logic [3:0]    lat,
	// sram port
	input  wire fre_sram_req_t req,
	output fre_sram_rsp_t      rsp
);
	// ------------------------------------------------------------
	// storage, written by the bench as the requester would
	// ------------------------------------------------------------
	logic [31:0] mem [0:15];
	logic [3:0]  cnt;
	// rdata toggles while no request is waiting and after each ack, and holds while the delay counts
	// so that a stale sample cannot look like a match
	always @(posedge aclk) begin
		if (!aresetn) begin
			rsp.ack <= 1'b0;
			rsp.rdata <= 32'h00000000;
			cnt <= 4'h0;
		end else if (rsp.ack || !req.req) begin
			rsp.ack <= 1'b0;
			rsp.rdata <= ~rsp.rdata;
		end else if (cnt >= lat) begin
			rsp.ack <= 1'b1;
			cnt <= 4'h0;
			if (req.we) begin
				mem[req.addr[5:2]] <= req.wdata;
			end else begin
				rsp.rdata <= mem[req.addr[5:2]];
			end
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule : fre_sram_model
`default_nettype wire

// ===== dv/flash_row_erase_syscall_bench.sv
// Purpose: self-checking bench of the row erase call block
// Assumes: bready and rready held high
// Notes: parameter block sits at word 4 of the memory model
`timescale 1ns/1ps
`default_nettype none
module flash_row_erase_syscall_bench
	import fre_pkg::*;
;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	localparam logic [31:0] PTR = 32'h20000010;
	logic          aclk = 1'b0;
	logic          aresetn = 1'b0;
	logic [7:0]    awaddr = 8'h00;
	logic [7:0]    araddr = 8'h00;
	logic          awvalid = 1'b0;
	logic          wvalid = 1'b0;
	logic          arvalid = 1'b0;
	logic [31:0]   wdata = 32'h00000000;
	logic          fw_hv_pulse = 1'b0;
	logic          fw_done = 1'b0;
	logic          flash_fail = 1'b0;
	logic [3:0]    lat = 4'h0;
	logic [3:0]    wstrb = 4'hf;
	logic          awready, wready, bvalid, arready, rvalid;
	logic [1:0]    bresp, rresp, rs;
	logic [31:0]   rdata, rd, row;
	fre_sram_req_t sram_o;
	fre_sram_rsp_t sram_i;
	fre_flash_t    flash_o;
	logic          hold_helper_core, stall_flash_reads, vcc_sel;
	logic          sys_reset_req, app_reset_req, call_done, irq;
	logic          fwm = 1'b0;
	logic          s_er, s_hold, s_stall;
	int            fails = 0;
	int            num_checks = 0;
	int            ecnt = 0;
	int            hv_n = 0;

	fre_row_erase dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(1'b1), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(1'b1), .sram_o(sram_o),
		.sram_i(sram_i), .flash_o(flash_o), .flash_fail(flash_fail),
		.fw_hv_pulse(fw_hv_pulse), .fw_done(fw_done),
		.hold_helper_core(hold_helper_core),
		.stall_flash_reads(stall_flash_reads),
		.sys_reset_req(sys_reset_req), .app_reset_req(app_reset_req),
		.vcc_sel(vcc_sel), .call_done(call_done), .irq(irq));
	fre_sram_model mdl (.aclk(aclk), .aresetn(aresetn), .lat(lat),
		.req(sram_o), .rsp(sram_i));

	// clock and watchdog; the longest erase is about 1000 cycles
	initial forever #4 aclk = ~aclk;
	initial begin
		repeat (30000) @(posedge aclk);
		fails++;
		complete_run();
	end
	// firmware stand-in plus a record of what happens during erase
	always @(posedge aclk) begin
		ecnt <= flash_o.erase_act ? ecnt + 1 : 0;
		fw_hv_pulse <= fwm && ecnt == 5;
		fw_done <= fwm && ecnt == 10;
		if (flash_o.erase_act) begin
			s_er = 1'b1;
			s_hold |= hold_helper_core;
			s_stall |= stall_flash_reads;
			row = flash_o.row_addr;
		end
		if (flash_o.hv_pulse) hv_n++;
	end
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		forever begin
			@(posedge aclk);
			if (ta && tw && bvalid) break;
			if (awvalid && awready) begin
				ta = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				tw = 1'b1;
				wvalid <= 1'b0;
			end
		end
		rs = bresp;
	endtask : wr
	task automatic rdr(input logic [7:0] a);
		logic t;
		t = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		forever begin
			@(posedge aclk);
			if (t && rvalid) break;
			if (arvalid && arready) begin
				t = 1'b1;
				arvalid <= 1'b0;
			end
		end
		rd = rdata;
		rs = rresp;
	endtask : rdr
	// start a call and wait for its completion pulse, bounded
	task automatic call(input logic [31:0] ch, input logic [1:0] rq);
		int n;
		s_er = 1'b0;
		s_hold = 1'b0;
		s_stall = 1'b0;
		hv_n = 0;
		row = 32'h00000000;
		wr(REG_CHAN, ch);
		wr(REG_CTRL, {29'h0, rq, 1'b1});
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (call_done !== 1'b1 && n < 5000);
		chk(n < 5000, 1);
	endtask : call
	task automatic sr(input logic [31:0] ch, input logic [1:0] rq,
		input logic app);
		mdl.mem[4] = ch;
		call(rq == 2'h0 ? ch : PTR, rq);
		@(posedge aclk);
		chk(sys_reset_req, !app);
		chk(app_reset_req, app);
		if (rq == 2'h0) begin
			rdr(REG_CHAN);
			chk(rd, 32'ha0000000);
		end else begin
			chk(mdl.mem[4], 32'ha0000000);
		end
	endtask : sr
	task automatic ecase(input logic [31:0] opw, ea, ret,
		input logic [1:0] rq, input logic fm, fl, eh, es, input int ehv);
		mdl.mem[4] = opw;
		mdl.mem[5] = ea;
		fwm = fm;
		flash_fail <= fl;
		call(PTR, rq);
		@(posedge aclk);
		chk(mdl.mem[4], ret);
		chk(s_er, ret[27:0] != 28'h1);
		chk(row, s_er ? ea & ~32'h000001ff : 32'h0);
		chk(s_hold, eh);
		chk(s_stall, es);
		chk(hv_n, ehv);
		chk({hold_helper_core, stall_flash_reads}, 0);
		chk({sys_reset_req, app_reset_req}, 0);
	endtask : ecase
	task automatic complete_run;
		$display("checks=%0d fails=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : complete_run
	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rdr(REG_STAT);
		chk(rd, 0);
		rdr(8'h20);
		chk({rs, rd}, {RESP_SLVERR, 32'h0});
		wr(8'h20, 32'h1);
		chk(rs, RESP_SLVERR);
		// the low byte lane of the channel word merges on its own
		wr(REG_CHAN, 32'h11223344);
		wstrb <= 4'h1;
		wr(REG_CHAN, 32'h55667788);
		wstrb <= 4'hf;
		rdr(REG_CHAN);
		chk(rd, 32'h11223388);
		sr(32'h1b000001, 2'h0, 1'b0);
		sr(32'h1b000003, 2'h0, 1'b1);
		sr(32'h1b000002, 2'h1, 1'b1);
		// debug port passing a pointer still gets the return word
		mdl.mem[4] = 32'h1b000000;
		call(PTR, 2'h0);
		@(posedge aclk);
		chk(sys_reset_req, 1);
		chk(app_reset_req, 0);
		rdr(REG_CHAN);
		chk(rd, 32'ha0000000);
		chk(mdl.mem[4], 32'h1b000000);
		// a reset type above one is refused without any reset
		call(32'h1b000005, 2'h0);
		@(posedge aclk);
		chk({sys_reset_req, app_reset_req}, 0);
		rdr(REG_CHAN);
		chk(rd, 32'hf0000001);
		// status is sticky, the interrupt follows the enable mask
		chk(irq, 0);
		wr(REG_IEN, 32'h1);
		chk(irq, 1);
		wr(REG_ICLR, 32'h3);
		chk(irq, 0);
		wr(REG_VSEL, 32'h1);
		chk(vcc_sel, 1);
		ecase(32'h1c5a0106, 32'h10001234, 32'ha0000000, 2'h2,
			1'b0, 1'b0, 1'b1, 1'b1, 500);
		wr(REG_VSEL, 32'h0);
		chk(vcc_sel, 0);
		wr(REG_IEN, 32'h2);
		rdr(REG_IEN);
		chk(rd, 32'h2);
		lat <= 4'h3;
		ecase(32'h1c000200, 32'h100003fc, 32'hf0000003, 2'h0,
			1'b1, 1'b1, 1'b0, 1'b0, 1);
		rdr(REG_STAT);
		chk({rd[1], irq}, 2'h3);
		wr(REG_ICLR, 32'h3);
		ecase(32'h14000106, 32'h0, 32'hf0000001, 2'h1,
			1'b0, 1'b0, 1'b0, 1'b0, 0);
		// a misaligned pointer is refused through the channel word
		call(32'h20000012, 2'h1);
		rdr(REG_CHAN);
		chk(rd, 32'hf0000002);
		// idle again, last requester kept, clear register reads zero
		rdr(REG_CTRL);
		chk(rd, 32'h00000002);
		rdr(REG_ICLR);
		chk(rd, 32'h00000000);
		complete_run();
	end
endmodule : flash_row_erase_syscall_bench
`default_nettype wire
